// ---- verilog/e1_receive_framer_control.sv ----
// e1 receive framer control: registers, zero-substitution decode, FAS/CRC4/CAS alignment, loss
// assumes line pins are asynchronous and the status groups and masks come from logic on i_clk
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "e1_rx_consts.svh"
module e1_receive_framer_control #(
  parameter logic [19:0] MF_SEARCH_CYCLES = 20'(`MF_SEARCH_MS * 1000 * `CLK_MHZ)
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [47:0] i_latched_status_flag_group,
  input wire logic [47:0] i_receive_alert_masks,
  input wire logic i_signaling_control_alt,
  input wire logic i_rx_line_clk,
  input wire logic i_rx_pos,
  input wire logic i_rx_neg,
  output logic o_rx_data,
  output logic o_rx_data_valid,
  output logic o_receive_channel_marker,
  output logic o_frame_aligned,
  output logic o_mf_aligned,
  output logic o_cas_aligned,
  output logic o_signal_loss
);
  // ========================================================================
  // registers
  logic [7:0] mode_r, ctl1_r, ctl2_r, rd_nxt, summary_r;
  logic [5:0] summary_nxt;
  logic act, resync_d_r, resync_rise;
  e1_rx_pkg::frame_state_t st_r;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_r <= `MODE_RESET;
      ctl1_r <= `CTL1_RESET;
      ctl2_r <= `CTL2_RESET;
    end else if (i_wr) begin
      // unused bits are dropped so they can never steer anything
      if (i_addr == `OFS_MASTER_MODE) mode_r <= i_wdata & `MODE_USED_MASK;
      if (i_addr == `OFS_CONTROL_ONE) ctl1_r <= i_wdata & `CTL1_USED_MASK;
      if (i_addr == `OFS_CONTROL_TWO) ctl2_r <= i_wdata & `CTL2_USED_MASK;
    end
  end

  always_comb begin
    for (int g = 0; g < 6; g++) begin
      summary_nxt[g] = |(i_latched_status_flag_group[8*g +: 8] &
                         ~i_receive_alert_masks[8*g +: 8]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) summary_r <= 8'h00;
    else summary_r <= {2'b00, summary_nxt};
  end

  always_comb begin
    case (i_addr)
      `OFS_MASTER_MODE: rd_nxt = mode_r;
      `OFS_CONTROL_ONE: rd_nxt = ctl1_r;
      `OFS_CONTROL_TWO: rd_nxt = ctl2_r;
      `OFS_SUMMARY: rd_nxt = summary_r;
      `OFS_FRAMER_STATE: rd_nxt = {3'b000, o_signal_loss, o_cas_aligned, o_mf_aligned,
                                   o_frame_aligned, act};
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) o_rdata <= 8'h00;
    else o_rdata <= i_rd ? rd_nxt : 8'h00;
  end

  // the processor runs only after init, enabled, E1 selected and out of soft reset
  assign act = mode_r[`MODE_INIT_DONE] & mode_r[`MODE_FRAMER_ENABLE] &
               mode_r[`MODE_STANDARD] & ~mode_r[`MODE_SOFT_RESET];

  always_ff @(posedge i_clk) begin
    if (i_reset) resync_d_r <= 1'b0;
    else resync_d_r <= ctl1_r[`CTL1_RESYNC];
  end
  assign resync_rise = ctl1_r[`CTL1_RESYNC] & ~resync_d_r;

  // ========================================================================
  // line sampling and zero-substitution decode
  logic [2:0] pin_q;
  logic lclk_d_r, tick, mark, viol, pol_r, dec_bit;
  logic [2:0] dl_r;
  logic [11:0] zrun_r;

  pin_sync #(.W(3)) u_pin_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_d({i_rx_line_clk, i_rx_pos, i_rx_neg}),
    .o_q(pin_q)
  );

  always_ff @(posedge i_clk) begin
    if (i_reset) lclk_d_r <= 1'b0;
    else lclk_d_r <= pin_q[2];
  end
  assign tick = pin_q[2] & ~lclk_d_r;
  assign mark = pin_q[1] | pin_q[0];
  // a mark of the same polarity as the previous one is a substitution violation
  assign viol = ctl1_r[`CTL1_ZS_DECODE] & mark & (pol_r == pin_q[1]);
  // fixed three-bit delay in both modes so frame timing never shifts with the decoder
  assign dec_bit = viol ? 1'b0 : dl_r[2];

  always_ff @(posedge i_clk) begin
    if (i_reset || !act) begin
      dl_r <= 3'h0;
      pol_r <= 1'b0;
      o_rx_data <= 1'b0;
      o_rx_data_valid <= 1'b0;
      zrun_r <= 12'h000;
    end else begin
      o_rx_data_valid <= tick;
      if (tick) begin
        dl_r <= viol ? 3'h0 : {dl_r[1:0], mark};
        if (mark) pol_r <= pin_q[1];
        o_rx_data <= dec_bit;
        if (mark) zrun_r <= 12'h000;
        else if (zrun_r != 12'hFFF) zrun_r <= zrun_r + 12'h001;
      end
    end
  end

  assign o_signal_loss = ctl2_r[`CTL2_LOSS_CRIT] ? (zrun_r >= `LOSS_ZEROS_LONG) :
                         (zrun_r >= `LOSS_ZEROS_SHORT);

  // ========================================================================
  // frame alignment
  logic [7:0] sh_r, sh_nxt, bit_pos_r;
  logic even_r, ts0_end, search_hit, fas_bad, nf_bad, fas_loss, crc_loss_r;
  logic [1:0] fas_err_r, nf_err_r;
  logic [3:0] mfr_r;
  logic mf_hit;

  assign sh_nxt = {sh_r[6:0], dec_bit};
  assign ts0_end = tick && bit_pos_r == 8'h07;
  assign search_hit = tick && st_r == e1_rx_pkg::ST_SEARCH && sh_nxt[6:0] == `FAS_WORD;
  assign fas_bad = sh_nxt[6:0] != `FAS_WORD;
  assign nf_bad = !sh_nxt[6];
  assign fas_loss = ts0_end && st_r == e1_rx_pkg::ST_SYNC &&
                    ((even_r && fas_bad && fas_err_r == 2'd2) ||
                     (ctl1_r[`CTL1_REALIGN_CRIT] && !even_r && nf_bad && nf_err_r == 2'd2));

  always_ff @(posedge i_clk) begin
    if (i_reset || !act) begin
      sh_r <= 8'h00;
      bit_pos_r <= 8'h00;
      even_r <= 1'b0;
      mfr_r <= 4'h0;
    end else if (tick) begin
      sh_r <= sh_nxt;
      if (search_hit) begin
        bit_pos_r <= 8'h08;
        even_r <= 1'b1;
      end else begin
        bit_pos_r <= bit_pos_r + 8'h01;
        if (bit_pos_r == 8'hFF) begin
          even_r <= ~even_r;
          mfr_r <= mfr_r + 4'h1;
        end
      end
      if (mf_hit) mfr_r <= `MF_FRAME_OF_WORD;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || !act) begin
      st_r <= e1_rx_pkg::ST_SLEEP;
    end else if (resync_rise) begin
      st_r <= e1_rx_pkg::ST_SEARCH;
    end else if (crc_loss_r) begin
      st_r <= e1_rx_pkg::ST_SEARCH;
    end else begin
      unique case (st_r)
        e1_rx_pkg::ST_SLEEP: st_r <= e1_rx_pkg::ST_SEARCH;
        e1_rx_pkg::ST_SEARCH: if (search_hit) st_r <= e1_rx_pkg::ST_CONF1;
        e1_rx_pkg::ST_CONF1: begin
          if (ts0_end) st_r <= nf_bad ? e1_rx_pkg::ST_SEARCH : e1_rx_pkg::ST_CONF2;
        end
        e1_rx_pkg::ST_CONF2: begin
          if (ts0_end) st_r <= fas_bad ? e1_rx_pkg::ST_SEARCH : e1_rx_pkg::ST_SYNC;
        end
        e1_rx_pkg::ST_SYNC: begin
          if (fas_loss) begin
            st_r <= ctl1_r[`CTL1_AUTO_OFF] ? e1_rx_pkg::ST_HOLD : e1_rx_pkg::ST_SEARCH;
          end
        end
        e1_rx_pkg::ST_HOLD: st_r <= e1_rx_pkg::ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || st_r != e1_rx_pkg::ST_SYNC) begin
      fas_err_r <= 2'd0;
      nf_err_r <= 2'd0;
    end else if (ts0_end) begin
      if (even_r) fas_err_r <= fas_bad ? fas_err_r + 2'd1 : 2'd0;
      else nf_err_r <= nf_bad ? nf_err_r + 2'd1 : 2'd0;
    end
  end

  assign o_frame_aligned = st_r == e1_rx_pkg::ST_SYNC;

  always_ff @(posedge i_clk) begin
    if (i_reset) o_receive_channel_marker <= 1'b0;
    else o_receive_channel_marker <= ctl1_r[`CTL1_SLOT26_MARK] && o_frame_aligned &&
                                     bit_pos_r == `SLOT26_BIT1_POS;
  end

  // ========================================================================
  // crc4 multiframe alignment and checking
  logic mf_run, mf_found_r, mf_al_r, prev_ok_r, smf_end, cw_bad, crc_d, crc_fb;
  logic [4:0] mf_sh_r;
  logic [19:0] mf_tmr_r;
  logic [3:0] crc_r, crc_upd, crc_prev_r, c_rx_r;
  logic [9:0] cw_cnt_r, ce_cnt_r, ce_sum;

  assign mf_run = o_frame_aligned && ctl1_r[`CTL1_MF_CHECK];
  assign mf_hit = ts0_end && mf_run && !even_r && !mf_al_r &&
                  {mf_sh_r, sh_nxt[7]} == `MFAS_WORD;
  // the check bit in the first position of FAS frames is counted as zero in the remainder
  assign crc_d = (even_r && bit_pos_r == 8'h00) ? 1'b0 : dec_bit;
  assign crc_fb = crc_r[3] ^ crc_d;
  assign crc_upd = {crc_r[2], crc_r[1], crc_r[0] ^ crc_fb, crc_fb};
  assign smf_end = tick && bit_pos_r == 8'hFF && mfr_r[2:0] == 3'h7;
  assign cw_bad = c_rx_r != crc_prev_r;
  assign ce_sum = ce_cnt_r + {9'h000, cw_bad};

  always_ff @(posedge i_clk) begin
    if (i_reset || !mf_run) begin
      mf_sh_r <= 5'h00;
      mf_found_r <= 1'b0;
      mf_al_r <= 1'b0;
      mf_tmr_r <= 20'h00000;
    end else begin
      if (ts0_end && !even_r) mf_sh_r <= {mf_sh_r[3:0], sh_nxt[7]};
      if (mf_hit) begin
        if (mf_found_r && mfr_r == `MF_FRAME_OF_WORD) mf_al_r <= 1'b1;
        mf_found_r <= 1'b1;
        mf_tmr_r <= 20'h00000;
      end else if (mf_found_r && !mf_al_r) begin
        if (mf_tmr_r >= MF_SEARCH_CYCLES) mf_found_r <= 1'b0;
        else mf_tmr_r <= mf_tmr_r + 20'h00001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || !mf_al_r) begin
      crc_r <= 4'h0;
      crc_prev_r <= 4'h0;
      c_rx_r <= 4'h0;
      prev_ok_r <= 1'b0;
      cw_cnt_r <= 10'd0;
      ce_cnt_r <= 10'd0;
      crc_loss_r <= 1'b0;
    end else begin
      crc_loss_r <= 1'b0;
      if (tick) crc_r <= smf_end ? 4'h0 : crc_upd;
      if (ts0_end && even_r) c_rx_r <= {c_rx_r[2:0], sh_nxt[7]};
      if (smf_end) begin
        crc_prev_r <= crc_upd;
        prev_ok_r <= 1'b1;
        // the received check bits cover the previous sub-multiframe
        if (prev_ok_r) begin
          if (cw_cnt_r == `CRC_WINDOW) begin
            crc_loss_r <= ce_sum >= `CRC_LOSS_LIMIT;
            cw_cnt_r <= 10'd0;
            ce_cnt_r <= 10'd0;
          end else begin
            cw_cnt_r <= cw_cnt_r + 10'd1;
            ce_cnt_r <= ce_sum;
          end
        end
      end
    end
  end

  assign o_mf_aligned = mf_al_r;

  // ========================================================================
  // cas multiframe alignment
  logic cas_run, cas_al_r, cas_err_r, nz_r, ts16_end;
  logic [3:0] cas_fr_r;
  logic [7:0] prev16_r;

  assign cas_run = o_frame_aligned && !ctl1_r[`CTL1_SIG_MODE];
  assign ts16_end = tick && bit_pos_r == `SLOT16_LAST_POS;

  always_ff @(posedge i_clk) begin
    if (i_reset || !cas_run) begin
      cas_al_r <= 1'b0;
      cas_err_r <= 1'b0;
      nz_r <= 1'b0;
      cas_fr_r <= 4'h0;
      prev16_r <= 8'h00;
    end else begin
      if (tick && bit_pos_r == 8'hFF) cas_fr_r <= cas_fr_r + 4'h1;
      if (ts16_end) begin
        prev16_r <= sh_nxt;
        if (!cas_al_r) begin
          if (sh_nxt[7:4] == 4'h0 && (!i_signaling_control_alt || prev16_r != 8'h00)) begin
            cas_al_r <= 1'b1;
            cas_fr_r <= 4'h0;
            cas_err_r <= 1'b0;
            nz_r <= 1'b0;
          end
        end else begin
          if (cas_fr_r == 4'h0) begin
            if (sh_nxt[7:4] != 4'h0) begin
              if (cas_err_r) cas_al_r <= 1'b0;
              cas_err_r <= 1'b1;
            end else begin
              cas_err_r <= 1'b0;
            end
          end
          if (cas_fr_r == 4'hF) begin
            if (!nz_r && sh_nxt == 8'h00) cas_al_r <= 1'b0;
            nz_r <= 1'b0;
          end else begin
            nz_r <= nz_r | (sh_nxt != 8'h00);
          end
        end
      end
    end
  end

  assign o_cas_aligned = cas_al_r;

  // ========================================================================
  // checks
  sleep_hold_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    !act |=> st_r == e1_rx_pkg::ST_SLEEP && !o_frame_aligned)
    else $error("framer left sleep while not enabled");

  soft_reset_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    mode_r[`MODE_SOFT_RESET] [*3] |-> st_r == e1_rx_pkg::ST_SLEEP && !o_mf_aligned)
    else $error("processor running during soft reset");

  summary_mask_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    (i_latched_status_flag_group[7:0] & ~i_receive_alert_masks[7:0]) == 8'h00
    |=> !summary_r[0] && summary_r[7:6] == 2'b00)
    else $error("masked flag reached summary");

  summary_set_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    (i_latched_status_flag_group[47:40] & ~i_receive_alert_masks[47:40]) != 8'h00
    |=> summary_r[5])
    else $error("unmasked group six flag missing from summary");

  resync_edge_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    act && $rose(ctl1_r[`CTL1_RESYNC]) |=> st_r == e1_rx_pkg::ST_SEARCH)
    else $error("resync edge did not restart search");

  fas_loss_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    act && fas_loss && !resync_rise && !crc_loss_r |=> !o_frame_aligned)
    else $error("alignment kept after three bad words");

  hold_stay_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    st_r == e1_rx_pkg::ST_HOLD && act && !resync_rise |=> st_r == e1_rx_pkg::ST_HOLD)
    else $error("automatic realign while disabled");

  marker_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    o_receive_channel_marker |-> $past(bit_pos_r) == `SLOT26_BIT1_POS &&
    $past(ctl1_r[`CTL1_SLOT26_MARK]))
    else $error("channel marker outside slot 26 bit 1");

  loss_short_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    !ctl2_r[`CTL2_LOSS_CRIT] && zrun_r == `LOSS_ZEROS_SHORT |-> o_signal_loss)
    else $error("signal loss not declared at 255 zeros");

  crc_loss_a:
  assert property (@(posedge i_clk) disable iff (i_reset)
    crc_loss_r && act && !resync_rise |=> st_r == e1_rx_pkg::ST_SEARCH && !o_mf_aligned)
    else $error("crc4 loss did not resync");
endmodule : e1_receive_framer_control

// ---- verilog/e1_rx_consts.svh ----
// offsets, field positions, reset values and timing counts for the e1 receive framer control
// assumes inclusion by bare name from the framer design files
`ifndef E1_RX_CONSTS_SVH
`define E1_RX_CONSTS_SVH

// ==========================================================================
// register map
`define OFS_MASTER_MODE 8'h80
`define OFS_CONTROL_ONE 8'h81
`define OFS_CONTROL_TWO 8'h82
`define OFS_SUMMARY 8'h9F
`define OFS_FRAMER_STATE 8'hE0
`define MODE_RESET 8'h00
`define CTL1_RESET 8'h00
`define CTL2_RESET 8'h00
`define MODE_USED_MASK 8'hC3
`define CTL1_USED_MASK 8'h7F
`define CTL2_USED_MASK 8'h01

// ==========================================================================
// field positions
`define MODE_FRAMER_ENABLE 7
`define MODE_INIT_DONE 6
`define MODE_SOFT_RESET 1
`define MODE_STANDARD 0
`define CTL1_ZS_DECODE 6
`define CTL1_SIG_MODE 5
`define CTL1_SLOT26_MARK 4
`define CTL1_MF_CHECK 3
`define CTL1_REALIGN_CRIT 2
`define CTL1_AUTO_OFF 1
`define CTL1_RESYNC 0
`define CTL2_LOSS_CRIT 0

// ==========================================================================
// framing patterns and counts
`define FAS_WORD 7'h1B
`define MFAS_WORD 6'h0B
`define MF_FRAME_OF_WORD 4'hB
`define SLOT26_BIT1_POS 8'hD0
`define SLOT16_LAST_POS 8'h87
`define CRC_WINDOW 10'd999
`define CRC_LOSS_LIMIT 10'd915
`define LOSS_ZEROS_SHORT 12'd255
`define LOSS_ZEROS_LONG 12'd2048
`define MF_SEARCH_MS 8
`define CLK_MHZ 100

`endif

// ---- verilog/e1_rx_pkg.sv ----
// types shared by the e1 receive framer control
// assumes the constants header is compiled alongside
package e1_rx_pkg;
  typedef enum logic [5:0] {
    ST_SLEEP = 6'h01,
    ST_SEARCH = 6'h02,
    ST_CONF1 = 6'h04,
    ST_CONF2 = 6'h08,
    ST_SYNC = 6'h10,
    ST_HOLD = 6'h20
  } frame_state_t;
endpackage : e1_rx_pkg

// ---- verilog/pin_sync.sv ----
// two-stage synchroniser for pins arriving from outside the clock domain
// assumes i_clk is the framer clock and i_reset is synchronous, active high
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule : pin_sync

// ---- sim/e1_line_source.sv ----
// line interface model: sends e1 frames of 256 bits as ami rails with a line clock
// assumes i_clk is the framer clock; one bit lasts 8 clock cycles, clock stands still when idle
`timescale 1ns/10ps
`include "e1_rx_consts.svh"
module e1_line_source (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_fas_ok,
  output logic o_line_clk,
  output logic o_pos,
  output logic o_neg
);
  logic [2:0] ph_r = 3'h0;
  logic [7:0] idx_r = 8'h00;
  logic odd_r = 1'b0;
  logic pol_r = 1'b0;
  logic fas_bit;
  logic bit_v;
  logic [6:0] fas_w;
  // ==========================================================================
  // frame content: payload is all ones, so no false alignment word can appear
  assign fas_w = i_fas_ok ? `FAS_WORD : ~`FAS_WORD;
  assign fas_bit = fas_w[3'h7 - idx_r[2:0]];
  always_comb begin
    bit_v = 1'b1;
    if (!odd_r && idx_r >= 8'h01 && idx_r <= 8'h07) begin
      bit_v = fas_bit;
    end
  end
  // ==========================================================================
  // rails change with the falling line clock, sampled at its rising half
  always_ff @(posedge i_clk) begin
    if (!i_run) begin
      ph_r <= 3'h0;
      o_line_clk <= 1'b0;
      o_pos <= 1'b0;
      o_neg <= 1'b0;
    end else begin
      ph_r <= ph_r + 3'h1;
      if (ph_r == 3'h0) begin
        o_line_clk <= 1'b0;
        o_pos <= bit_v & ~pol_r;
        o_neg <= bit_v & pol_r;
        if (bit_v) begin
          pol_r <= ~pol_r;
        end
      end
      if (ph_r == 3'h4) begin
        o_line_clk <= 1'b1;
        idx_r <= idx_r + 8'h01;
        if (idx_r == 8'hFF) begin
          odd_r <= ~odd_r;
        end
      end
    end
  end
endmodule : e1_line_source

// ---- sim/tb_top.sv ----
// testbench for the e1 receive framer control: registers, summary, sleep, alignment and loss
// assumes the line model above; short multiframe search count for run time
`timescale 1ns/10ps
`include "e1_rx_consts.svh"
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic [47:0] flags = 48'h0;
  logic [47:0] masks = 48'h0;
  logic run = 1'b0;
  logic fas_ok = 1'b1;
  logic lclk, lpos, lneg;
  logic o_rx_data, o_rx_data_valid, o_receive_channel_marker;
  logic o_frame_aligned, o_mf_aligned, o_cas_aligned, o_signal_loss;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  logic [7:0] d;
  always #5 i_clk = ~i_clk;
  e1_receive_framer_control #(.MF_SEARCH_CYCLES(20'd70000)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_latched_status_flag_group(flags),
    .i_receive_alert_masks(masks), .i_signaling_control_alt(1'b0), .i_rx_line_clk(lclk),
    .i_rx_pos(lpos), .i_rx_neg(lneg), .o_rx_data(o_rx_data), .o_rx_data_valid(o_rx_data_valid),
    .o_receive_channel_marker(o_receive_channel_marker), .o_frame_aligned(o_frame_aligned),
    .o_mf_aligned(o_mf_aligned), .o_cas_aligned(o_cas_aligned), .o_signal_loss(o_signal_loss));
  e1_line_source line (.i_clk(i_clk), .i_run(run), .i_fas_ok(fas_ok), .o_line_clk(lclk),
    .o_pos(lpos), .o_neg(lneg));
  // ==========================================================================
  // bus tasks and helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  // waits up to n cycles for the alignment flag to reach v
  task automatic wait_al(input logic v, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      if (o_frame_aligned === v) break;
    end
    #1;
  endtask : wait_al
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] ofs [4] = '{`OFS_MASTER_MODE, `OFS_CONTROL_ONE, `OFS_CONTROL_TWO, `OFS_SUMMARY};
    logic [7:0] msk [4] = '{`MODE_USED_MASK, `CTL1_USED_MASK, `CTL2_USED_MASK, 8'h00};
    for (int k = 0; k < 4; k++) begin
      rd(ofs[k], d);
      `CHECK(d, 8'h00)
      wr(ofs[k], 8'hFF);
      rd(ofs[k], d);
      `CHECK(d, msk[k])
      wr(ofs[k], 8'h00);
    end
    wr(8'h90, 8'hA5);
    rd(8'h90, d);
    `CHECK(d, 8'h00)
  endtask : t_regs
  task automatic t_summary();
    flags <= 48'h8000_0000_0201;
    masks <= 48'h7F00_0000_0001;
    repeat (3) @(posedge i_clk);
    rd(`OFS_SUMMARY, d);
    `CHECK(d, 8'h22)
    flags <= 48'h8000_0000_0001;
    repeat (3) @(posedge i_clk);
    rd(`OFS_SUMMARY, d);
    `CHECK(d, 8'h20)
    masks <= 48'hFF00_0000_0001;
    repeat (3) @(posedge i_clk);
    rd(`OFS_SUMMARY, d);
    `CHECK(d, 8'h00)
    flags <= 48'h0;
  endtask : t_summary
  task automatic t_sleep();
    logic [7:0] modes [3] = '{8'h81, 8'h41, 8'hC0};
    for (int k = 0; k < 3; k++) begin
      wr(`OFS_MASTER_MODE, modes[k]);
      wait_al(1'b1, 5000);
      `CHECK(o_frame_aligned, 1'b0)
      rd(`OFS_FRAMER_STATE, d);
      `CHECK(d, 8'h00)
    end
    wr(`OFS_MASTER_MODE, 8'h00);
  endtask : t_sleep
  task automatic t_align();
    wr(`OFS_CONTROL_ONE, 8'h20);
    wr(`OFS_MASTER_MODE, 8'h81);
    wr(`OFS_MASTER_MODE, 8'hC1);
    wait_al(1'b1, 10000);
    `CHECK(o_frame_aligned, 1'b1)
    rd(`OFS_FRAMER_STATE, d);
    `CHECK(d, 8'h03)
    for (int k = 0; k < 20; k++) begin
      @(negedge i_clk);
      if (o_rx_data_valid === 1'b1) break;
    end
    `CHECK(o_rx_data_valid, 1'b1)
  endtask : t_align
  task automatic t_marker();
    wr(`OFS_CONTROL_ONE, 8'h30);
    for (int k = 0; k < 2200; k++) begin
      @(posedge i_clk);
      if (o_receive_channel_marker === 1'b1) break;
    end
    #1;
    `CHECK(o_receive_channel_marker, 1'b1)
    `CHECK(o_cas_aligned, 1'b0)
    wr(`OFS_CONTROL_ONE, 8'h20);
  endtask : t_marker
  task automatic t_loss();
    wr(`OFS_CONTROL_ONE, 8'h22);
    fas_ok <= 1'b0;
    wait_al(1'b0, 14000);
    `CHECK(o_frame_aligned, 1'b0)
    fas_ok <= 1'b1;
    wait_al(1'b1, 10000);
    `CHECK(o_frame_aligned, 1'b0)
    wr(`OFS_CONTROL_ONE, 8'h23);
    wait_al(1'b1, 10000);
    `CHECK(o_frame_aligned, 1'b1)
    wr(`OFS_CONTROL_ONE, 8'h20);
  endtask : t_loss
  task automatic t_soft_reset();
    wr(`OFS_MASTER_MODE, 8'hC3);
    wait_al(1'b1, 5000);
    wait_al(1'b0, 100);
    repeat (4000) @(posedge i_clk);
    #1;
    `CHECK(o_frame_aligned, 1'b0)
    wr(`OFS_MASTER_MODE, 8'hC1);
    wait_al(1'b1, 10000);
    `CHECK(o_frame_aligned, 1'b1)
  endtask : t_soft_reset
  // ==========================================================================
  // cycle ceiling sized for the sequence below, about 60000 cycles
  always @(posedge i_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 98000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs();
    for (int a = 0; a < 128; a++) begin
      wr(8'(a), 8'h00);
    end
    t_summary();
    run <= 1'b1;
    t_sleep();
    t_align();
    t_marker();
    t_loss();
    t_soft_reset();
    complete_run();
  end
endmodule : tb_top
